// ---- logic/autoneg_np_pkg.sv ----
// Constants for the auto-negotiation next-page register pair
package autoneg_np_pkg;
  // ==========================================================
  // Management addresses and widths
  localparam int          ADDR_W            = 5;
  localparam int          DATA_W            = 16;
  localparam int          CODE_W            = 11;
  localparam logic [4:0]  ADDR_NP_TRANSMIT  = 5'h07;
  localparam logic [4:0]  ADDR_PARTNER_NP   = 5'h08;
  // ==========================================================
  // Field positions of a next-page link control word
  localparam int          POS_MORE_PAGES    = 15;
  localparam int          POS_RESERVED      = 14;
  localparam int          POS_PAGE_FORMAT   = 13;
  localparam int          POS_COMPLY_ACK    = 12;
  localparam int          POS_TOGGLE        = 11;
  localparam int          POS_CODE_HI       = 10;
  // ==========================================================
  // Reset values
  localparam logic        RST_MORE_PAGES    = 1'b0;
  localparam logic        RST_PAGE_FORMAT   = 1'b1;
  localparam logic        RST_COMPLY_ACK    = 1'b0;
  localparam logic        RST_TOGGLE        = 1'b0;
  localparam logic [10:0] RST_CODE          = 11'h001;
  localparam logic [15:0] RST_PARTNER_NP    = 16'h0000;
  localparam logic [15:0] RDATA_UNMAPPED    = 16'h0000;
endpackage

// ---- logic/autoneg_next_page_registers.sv ----
// Auto-negotiation next-page transmit and link partner next-page registers
`timescale 1ns/1ns
// Operation
// - More-pages register bit 15 is copied into each outgoing next-page word.
// - More-pages zero marks the final page, one marks further pages follow.
// - Next pages go out only with more-pages set and partner next-page able.
// - Transmit register bit 14 is reserved and always reads zero.
// - Transmit bit 13 drives the page-format bit: zero unformatted, one message.
// - Transmit bit 12 drives the comply-acknowledge bit of the outgoing word.
// - Toggle bit 11 is sent and inverts on each transmitted next-page word, except in a cycle that also sends the base word.
// - First next-page toggle is the inverse of base word bit 11.
// - Transmit bits 10 to 0 form the eleven-bit code field sent.
// - Read-only partner register at address 8 holds received fields, reset zero.
// - Partner register bit 14 is reserved and always reads zero.
// - Page-received status latches on a stored word, clears on expansion read unless a word is stored in the same cycle.
module autoneg_next_page_registers
  import autoneg_np_pkg::*;
(
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST_B,
  input  wire logic [autoneg_np_pkg::ADDR_W-1:0] MGMT_ADDR,
  input  wire logic                             MGMT_WR,
  input  wire logic                             MGMT_RD,
  input  wire logic [autoneg_np_pkg::DATA_W-1:0] MGMT_WDATA,
  output logic      [autoneg_np_pkg::DATA_W-1:0] MGMT_RDATA,
  output logic                                  MGMT_RVALID,
  input  wire logic                             EXP_RD,
  input  wire logic                             BASE_SENT,
  input  wire logic                             BASE_BIT11,
  input  wire logic                             NP_SENT,
  input  wire logic                             PARTNER_NP_ABLE,
  input  wire logic                             RX_NP_VALID,
  input  wire logic [autoneg_np_pkg::DATA_W-1:0] RX_NP_WORD,
  output logic      [autoneg_np_pkg::DATA_W-1:0] NP_TX_WORD,
  output logic                                  NP_TX_ENABLE,
  output logic                                  PAGE_RECEIVED
);
  import autoneg_np_pkg::*;

  // ==========================================================
  // Reset release
  logic              rst_meta_r;
  logic              rst_sync_r;
  logic              rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // ==========================================================
  // Transmit register fields
  logic              more_pages_flag_r;
  logic              page_format_flag_r;
  logic              comply_acknowledge_r;
  logic              toggle_r;
  logic [CODE_W-1:0] code_r;
  logic [DATA_W-1:0] partner_np_r;
  logic              wr_tx;
  logic              rd_exp_hit;

  function automatic logic [DATA_W-1:0] pack_word(input logic mp, input logic pf, input logic ack,
                                                  input logic tg, input logic [CODE_W-1:0] code);
    pack_word = {mp, 1'b0, pf, ack, tg, code};
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    addr_is = (a == target);
  endfunction

  assign wr_tx      = MGMT_WR && addr_is(MGMT_ADDR, ADDR_NP_TRANSMIT);
  assign rd_exp_hit = EXP_RD;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      more_pages_flag_r    <= RST_MORE_PAGES;
      page_format_flag_r   <= RST_PAGE_FORMAT;
      comply_acknowledge_r <= RST_COMPLY_ACK;
      code_r               <= RST_CODE;
    end else if (wr_tx) begin
      more_pages_flag_r    <= MGMT_WDATA[POS_MORE_PAGES];
      page_format_flag_r   <= MGMT_WDATA[POS_PAGE_FORMAT];
      comply_acknowledge_r <= MGMT_WDATA[POS_COMPLY_ACK];
      code_r               <= MGMT_WDATA[POS_CODE_HI:0];
    end
  end

  // ==========================================================
  // Toggle bit
  // seeded from base word, flips per sent word
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= RST_TOGGLE;
    end else if (BASE_SENT) begin
      toggle_r <= ~BASE_BIT11;
    end else if (NP_SENT) begin
      toggle_r <= ~toggle_r;
    end
  end

  // ==========================================================
  // Outgoing word and enable
  // outgoing word assembly
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      NP_TX_WORD <= pack_word(RST_MORE_PAGES, RST_PAGE_FORMAT, RST_COMPLY_ACK, RST_TOGGLE, RST_CODE);
    end else begin
      NP_TX_WORD <= pack_word(more_pages_flag_r, page_format_flag_r, comply_acknowledge_r, toggle_r, code_r);
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      NP_TX_ENABLE <= 1'b0;
    end else begin
      NP_TX_ENABLE <= more_pages_flag_r && PARTNER_NP_ABLE;
    end
  end

  // ==========================================================
  // Partner register and page-received status
  // whole-word capture, reserved bit zero
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      partner_np_r <= RST_PARTNER_NP;
    end else if (RX_NP_VALID) begin
      partner_np_r <= RX_NP_WORD & ~(DATA_W'(1) << POS_RESERVED);
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PAGE_RECEIVED <= 1'b0;
    end else if (RX_NP_VALID) begin
      PAGE_RECEIVED <= 1'b1;
    end else if (rd_exp_hit) begin
      PAGE_RECEIVED <= 1'b0;
    end
  end

  // ==========================================================
  // Management read port
  // read mux
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      MGMT_RDATA  <= RDATA_UNMAPPED;
      MGMT_RVALID <= 1'b0;
    end else begin
      MGMT_RVALID <= MGMT_RD;
      if (MGMT_RD) begin
        case (MGMT_ADDR)
          ADDR_NP_TRANSMIT: begin
            MGMT_RDATA <= pack_word(more_pages_flag_r, page_format_flag_r, comply_acknowledge_r, toggle_r, code_r);
          end
          ADDR_PARTNER_NP: begin
            MGMT_RDATA <= partner_np_r;
          end
          default: begin
            MGMT_RDATA <= RDATA_UNMAPPED;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  sequence s_tx_write;
    wr_tx;
  endsequence

  sequence s_np_sent;
    NP_SENT && !BASE_SENT;
  endsequence

  sequence s_read_tx;
    MGMT_RD && addr_is(MGMT_ADDR, ADDR_NP_TRANSMIT);
  endsequence

  sequence s_read_partner;
    MGMT_RD && addr_is(MGMT_ADDR, ADDR_PARTNER_NP);
  endsequence

  sequence s_read_other;
    MGMT_RD && !addr_is(MGMT_ADDR, ADDR_NP_TRANSMIT) && !addr_is(MGMT_ADDR, ADDR_PARTNER_NP);
  endsequence

  sequence s_read_pulse;
    MGMT_RD ##1 !MGMT_RD;
  endsequence

  a_more_pages_copy: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_tx_write |=> ##1 NP_TX_WORD[POS_MORE_PAGES] == $past(MGMT_WDATA[POS_MORE_PAGES], 2))
    else $error("more-pages bit not carried to outgoing word");

  a_np_enable_gate: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    NP_TX_ENABLE == ($past(more_pages_flag_r) && $past(PARTNER_NP_ABLE)))
    else $error("next-page enable not gated by partner ability");

  a_tx_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_tx |=> MGMT_RVALID && !MGMT_RDATA[POS_RESERVED])
    else $error("transmit reserved bit read nonzero");

  a_fields_follow: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_tx_write |=> ##1 NP_TX_WORD[POS_PAGE_FORMAT:POS_COMPLY_ACK] ==
      $past(MGMT_WDATA[POS_PAGE_FORMAT:POS_COMPLY_ACK], 2))
    else $error("page-format or acknowledge bit not carried");

  a_code_follow: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_tx_write |=> ##1 NP_TX_WORD[POS_CODE_HI:0] == $past(MGMT_WDATA[POS_CODE_HI:0], 2))
    else $error("code field not carried");

  a_toggle_flip: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_np_sent |=> toggle_r != $past(toggle_r) ##1 NP_TX_WORD[POS_TOGGLE] == $past(toggle_r))
    else $error("toggle did not invert after sent word");

  a_toggle_seed: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    BASE_SENT |=> toggle_r == !$past(BASE_BIT11))
    else $error("first toggle not inverse of base bit 11");

  a_partner_capture: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    RX_NP_VALID |=> partner_np_r == ($past(RX_NP_WORD) & 16'hbfff) && !partner_np_r[POS_RESERVED])
    else $error("partner word not captured whole");

  a_page_rx_latch: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    RX_NP_VALID |=> PAGE_RECEIVED ##1 (PAGE_RECEIVED || $past(rd_exp_hit && !RX_NP_VALID)))
    else $error("page-received status not latched");

  a_partner_read: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_partner |=> MGMT_RDATA == $past(partner_np_r))
    else $error("partner register read mismatch");

  a_tx_readback: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_tx |=> MGMT_RDATA[POS_TOGGLE] == $past(toggle_r) &&
      MGMT_RDATA[POS_MORE_PAGES] == $past(more_pages_flag_r))
    else $error("transmit register readback mismatch");

  a_partner_reserved: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_partner |=> MGMT_RVALID && !MGMT_RDATA[POS_RESERVED])
    else $error("partner reserved bit read nonzero");

  a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_other |=> MGMT_RVALID && MGMT_RDATA == RDATA_UNMAPPED)
    else $error("unmapped address read nonzero");

  a_read_pulse: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    s_read_pulse |-> MGMT_RVALID ##1 !MGMT_RVALID)
    else $error("read answer not a single cycle");

  a_rdata_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !MGMT_RD |=> $stable(MGMT_RDATA))
    else $error("read data changed without a read");

  a_partner_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !RX_NP_VALID |=> $stable(partner_np_r))
    else $error("partner register changed without a word");

  a_tx_fields_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !wr_tx |=> $stable({more_pages_flag_r, page_format_flag_r, comply_acknowledge_r, code_r}))
    else $error("transmit fields changed without a write");

  a_toggle_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !BASE_SENT && !NP_SENT |=> $stable(toggle_r))
    else $error("toggle changed without a sent word");

  a_set_beats_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    RX_NP_VALID && rd_exp_hit |=> PAGE_RECEIVED)
    else $error("page-received lost to a same-cycle clear");

  a_status_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    rd_exp_hit && !RX_NP_VALID |=> !PAGE_RECEIVED)
    else $error("page-received not cleared by expansion read");

  a_status_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !RX_NP_VALID && !rd_exp_hit |=> $stable(PAGE_RECEIVED))
    else $error("page-received changed without an event");

  a_final_page_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !more_pages_flag_r |=> !NP_TX_ENABLE)
    else $error("next pages enabled after final page");

endmodule

// ---- tb/mgmt_station.sv ----
// Station management model driving the register strobes
`timescale 1ns/1ns
module mgmt_station
  import autoneg_np_pkg::*;
(
  input  wire logic                              clk,
  output logic      [autoneg_np_pkg::ADDR_W-1:0] addr,
  output logic                                  wr,
  output logic                                  rd,
  output logic      [autoneg_np_pkg::DATA_W-1:0] wdata,
  input  wire logic [autoneg_np_pkg::DATA_W-1:0] rdata,
  input  wire logic                             rvalid
);
  initial begin
    addr = 5'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr = 1'b1;
    wdata = d & 16'hbfff;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~wdata;
  endtask
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
    v = rvalid;
  endtask
endmodule

// ---- tb/test_autoneg_next_page_registers.sv ----
// Self-checking bench for the next-page register pair
`timescale 1ns/1ns
module test_autoneg_next_page_registers;
  import autoneg_np_pkg::*;
  logic        clk_sys, rst_b, exp_rd, base_sent, base_bit11, np_sent, np_able, rx_valid;
  logic        wr, rd, rvalid, tx_en, page_rx;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, rx_word, tx_word, rd_val;
  int          miscompares = 0;
  int          cmp_count = 0;
  mgmt_station sta (.clk(clk_sys), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  autoneg_next_page_registers dut (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .MGMT_ADDR(addr), .MGMT_WR(wr), .MGMT_RD(rd),
    .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid), .EXP_RD(exp_rd),
    .BASE_SENT(base_sent), .BASE_BIT11(base_bit11), .NP_SENT(np_sent),
    .PARTNER_NP_ABLE(np_able), .RX_NP_VALID(rx_valid), .RX_NP_WORD(rx_word),
    .NP_TX_WORD(tx_word), .NP_TX_ENABLE(tx_en), .PAGE_RECEIVED(page_rx));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic v;
    sta.read_reg(a, rd_val, v);
    chk({15'h0000, v}, 16'h0001);
    chk(rd_val, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Strobes in order base, next page, receive, expansion read
  task automatic ev(input logic [3:0] s, input logic b11);
    @(posedge clk_sys);
    #1;
    {base_sent, np_sent, rx_valid, exp_rd} = s;
    base_bit11 = b11;
    @(posedge clk_sys);
    #1;
    {base_sent, np_sent, rx_valid, exp_rd} = 4'h0;
    rx_word = ~rx_word;
    base_bit11 = ~b11;
    settle;
  endtask
  initial begin
    for (int i = 0; i < 20000; i++) @(posedge clk_sys);
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst_b = 1'b0;
    {base_sent, np_sent, rx_valid, exp_rd, base_bit11, np_able} = 6'h00;
    rx_word = 16'h0000;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(tx_word, 16'h2001);
    rchk(ADDR_NP_TRANSMIT, 16'h2001);
    rchk(ADDR_PARTNER_NP, RST_PARTNER_NP);
    chk({15'h0000, page_rx}, 16'h0000);
    sta.write_reg(ADDR_NP_TRANSMIT, 16'hbfff);
    settle;
    rchk(ADDR_NP_TRANSMIT, 16'hb7ff);
    chk(tx_word, 16'hb7ff);
    chk({15'h0000, tx_en}, 16'h0000);
    np_able = 1'b1;
    settle;
    chk({15'h0000, tx_en}, 16'h0001);
    sta.write_reg(ADDR_NP_TRANSMIT, 16'h0555);
    settle;
    chk(tx_word, 16'h0555);
    chk({15'h0000, tx_en}, 16'h0000);
    ev(4'h8, 1'b0);
    chk(tx_word & 16'h0800, 16'h0800);
    ev(4'h4, 1'b0);
    chk(tx_word & 16'h0800, 16'h0000);
    ev(4'h4, 1'b0);
    chk(tx_word & 16'h0800, 16'h0800);
    ev(4'hc, 1'b0);
    chk(tx_word & 16'h0800, 16'h0800);
    rchk(ADDR_NP_TRANSMIT, 16'h0d55);
    rx_word = 16'hffff;
    ev(4'h2, 1'b0);
    chk({15'h0000, page_rx}, 16'h0001);
    rchk(ADDR_PARTNER_NP, 16'hbfff);
    sta.write_reg(ADDR_PARTNER_NP, 16'h0000);
    settle;
    rchk(ADDR_PARTNER_NP, 16'hbfff);
    rx_word = 16'h2a55;
    ev(4'h2, 1'b0);
    rchk(ADDR_PARTNER_NP, 16'h2a55);
    ev(4'h1, 1'b0);
    chk({15'h0000, page_rx}, 16'h0000);
    rx_word = 16'hc3a5;
    ev(4'h3, 1'b0);
    chk({15'h0000, page_rx}, 16'h0001);
    rchk(ADDR_PARTNER_NP, 16'h83a5);
    rst_b = 1'b0;
    settle;
    rst_b = 1'b1;
    settle;
    chk({15'h0000, page_rx}, 16'h0000);
    chk(tx_word, 16'h2001);
    chk({15'h0000, tx_en}, 16'h0000);
    rchk(ADDR_PARTNER_NP, RST_PARTNER_NP);
    rchk(5'h1f, RDATA_UNMAPPED);
    report_and_stop;
  end
endmodule
